//--- cops_ctrl.sv
// cops_ctrl: power-down and output-halt sequencing for up to eight differential clock pairs
// assumes: pins synchronous to clk; comp_edge_rise/fall mark edges of the complementary output clock
`timescale 1ns/1ns
`default_nettype none
module cops_ctrl
	import cops_pkg::*;
#(
	parameter int n_out        = 8,
	parameter int lock_cycles  = COPS_LOCK_CYCLES,
	parameter int pd_drive_cyc = COPS_PD_DRIVE_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 power_down_n,
	input  wire logic                 output_halt_n,
	input  wire logic                 comp_edge_rise,
	input  wire logic                 comp_edge_fall,
	input  wire logic                 reg_wr,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	output var  logic [7:0]           reg_rdata,
	output var  logic [7:0]           readback_count_bits,
	output var  logic                 pll_enable,
	output var  logic                 pll_locked,
	output var  logic [n_out-1:0]     clock_run,
	output var  logic [n_out-1:0]     clock_out_true_oe,
	output var  logic [n_out-1:0]     clock_out_true_level,
	output var  logic [n_out-1:0]     clock_out_true_strong,
	output var  logic [n_out-1:0]     clock_out_comp_oe,
	output var  logic [n_out-1:0]     clock_out_comp_level
);

	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (n_out < 1 || n_out > 8) begin : g_bad_n_out
		$error("cops_ctrl: n_out must be 1..8");
	end
	if (lock_cycles < 2 || lock_cycles > 65535) begin : g_bad_lock
		$error("cops_ctrl: lock_cycles out of range");
	end
	// the wake window is counted inside the lock window, so it has to be the shorter one
	if (pd_drive_cyc < 1 || pd_drive_cyc >= lock_cycles) begin : g_bad_wake
		$error("cops_ctrl: pd_drive_cyc out of range");
	end
	// the restart counter is three bits wide
	if (COPS_RESTART_MIN < 1 || COPS_RESTART_MIN > 6) begin : g_bad_restart
		$error("cops_ctrl: restart count does not fit its counter");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	cops_regreq_type req;
	assign req = '{wdata: reg_wdata, addr: reg_addr, wr: reg_wr};

	logic [7:0] drive_mode_r;
	logic [7:0] enable_r;
	logic [7:0] stoppable_r;
	logic [7:0] part_ident_r;
	logic [7:0] readback_cnt_r;

	function automatic logic hit(input cops_regreq_type r, input logic [7:0] ofs);
		hit = r.wr && (r.addr == ofs);
	endfunction : hit

	// one strobe per writable register; offset 0x04 has none, so it stays read-only
	wire logic wr_drive_mode = hit(req, COPS_OFS_DRIVE_MODE);
	wire logic wr_enable     = hit(req, COPS_OFS_ENABLE);
	wire logic wr_stoppable  = hit(req, COPS_OFS_STOPPABLE);
	wire logic wr_part_ident = hit(req, COPS_OFS_PART_IDENT);
	wire logic wr_readback   = hit(req, COPS_OFS_READBACK_CNT);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			drive_mode_r   <= COPS_RST_DRIVE_MODE;
			enable_r       <= COPS_RST_ENABLE;
			stoppable_r    <= COPS_RST_STOPPABLE;
			part_ident_r   <= COPS_RST_PART_IDENT;
			readback_cnt_r <= COPS_RST_READBACK_CNT;
		end else begin
			if (wr_drive_mode) drive_mode_r   <= req.wdata;
			if (wr_enable)     enable_r       <= req.wdata;
			if (wr_stoppable)  stoppable_r    <= req.wdata;
			if (wr_part_ident) part_ident_r   <= req.wdata;
			if (wr_readback)   readback_cnt_r <= req.wdata;
		end
	end

	// revision/vendor identification is wired, writes to it are ignored
	wire logic [7:0] rev_vendor = {COPS_REVISION_CODE, COPS_MAKER_CODE};

	logic [7:0] rdata_mux;
	always_comb begin
		case (reg_addr)
			COPS_OFS_DRIVE_MODE:   rdata_mux = drive_mode_r;
			COPS_OFS_ENABLE:       rdata_mux = enable_r;
			COPS_OFS_STOPPABLE:    rdata_mux = stoppable_r;
			COPS_OFS_REV_VENDOR:   rdata_mux = rev_vendor;
			COPS_OFS_PART_IDENT:   rdata_mux = part_ident_r;
			COPS_OFS_READBACK_CNT: rdata_mux = readback_cnt_r;
			default:               rdata_mux = 8'h00;
		endcase
	end

	wire logic pd_sel   = drive_mode_r[COPS_BIT_PD_DRIVE_SELECT];
	wire logic halt_sel = drive_mode_r[COPS_BIT_HALT_DRIVE_SELECT];

	// ----------------------------------------------------------------
	// pin debounce on complementary rising edges
	// ----------------------------------------------------------------
	logic pd_n_db;
	logic halt_n_db;

	cops_debounce #(
		.level_rst (1'b1),
		.edges     (COPS_DEBOUNCE_EDGES)
	) u_pd_db (
		.clk       (clk),
		.rst_n     (rst_n),
		.sample_en (comp_edge_rise),
		.level_in  (power_down_n),
		.level_out (pd_n_db)
	);

	cops_debounce #(
		.level_rst (1'b1),
		.edges     (COPS_DEBOUNCE_EDGES)
	) u_halt_db (
		.clk       (clk),
		.rst_n     (rst_n),
		.sample_en (comp_edge_rise),
		.level_in  (output_halt_n),
		.level_out (halt_n_db)
	);

	// ----------------------------------------------------------------
	// power-down sequencer
	// ----------------------------------------------------------------
	cops_state_type state_r;
	cops_state_type state_nxt;
	logic [15:0]    wait_r;
	logic [15:0]    wait_nxt;

	// the wake side reads the raw pin: release is not debounced, entry is
	always_comb begin
		state_nxt = state_r;
		wait_nxt  = wait_r;
		case (state_r)
			COPS_ST_RUN: begin
				if (!pd_n_db) state_nxt = COPS_ST_PD_PARK;
			end
			COPS_ST_PD_PARK: begin
				if (comp_edge_fall) state_nxt = COPS_ST_PD_OFF;
			end
			COPS_ST_PD_OFF: begin
				if (power_down_n) begin
					state_nxt = COPS_ST_PD_WAKE;
					wait_nxt  = 16'h0000;
				end
			end
			COPS_ST_PD_WAKE: begin
				wait_nxt = wait_r + 16'h0001;
				if (wait_r == 16'(pd_drive_cyc - 1)) state_nxt = COPS_ST_LOCKWAIT;
			end
			COPS_ST_LOCKWAIT: begin
				wait_nxt = wait_r + 16'h0001;
				if (wait_r == 16'(lock_cycles - 1)) state_nxt = COPS_ST_RUN;
			end
			default: state_nxt = COPS_ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= COPS_ST_RUN;
			wait_r  <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			wait_r  <= wait_nxt;
		end
	end

	wire logic in_run    = (state_r == COPS_ST_RUN);
	wire logic in_park   = (state_r == COPS_ST_PD_PARK);
	wire logic in_off    = (state_r == COPS_ST_PD_OFF);
	wire logic pd_waking = (state_r == COPS_ST_PD_WAKE);
	wire logic parked_pd = in_off || pd_waking;
	// pll stays on until outputs are parked, and restarts on wake
	wire logic pll_on    = !in_off;
	// still locked while the park waits for its falling edge, so the outputs keep running until then
	wire logic locked    = in_run || in_park;

	// ----------------------------------------------------------------
	// halt / restart
	// ----------------------------------------------------------------
	logic [n_out-1:0] halted_r;
	logic [2:0]       restart_r;
	logic             restart_pend_r;

	wire logic [n_out-1:0] halt_mask = stoppable_r[n_out-1:0] & enable_r[n_out-1:0];
	wire logic             halt_set  = !halt_n_db && comp_edge_fall;
	// restart on the third falling edge after arming: only then have two full periods passed
	// since the release was recognised, which the second edge would not guarantee
	wire logic restart_go = restart_pend_r && comp_edge_fall &&
		(restart_r == 3'(COPS_RESTART_MIN));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			halted_r       <= '0;
			restart_r      <= 3'h0;
			restart_pend_r <= 1'b0;
		end else begin
			if (!halt_n_db) begin
				restart_pend_r <= 1'b0;
				restart_r      <= 3'h0;
				// stop after the next falling edge of the complementary output
				if (halt_set)
					halted_r <= halted_r | halt_mask;
			end else if (|halted_r && !restart_pend_r) begin
				restart_pend_r <= 1'b1;
			end else if (restart_pend_r && comp_edge_fall) begin
				restart_r <= restart_r + 3'h1;
				if (restart_go) begin
					halted_r       <= '0;
					restart_pend_r <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// pin state per output pair
	// ----------------------------------------------------------------
	// a halted pair in floating mode is driven high again as soon as restart is armed
	wire logic halt_rel_drive = restart_pend_r;

	// pin patterns of one pair; a floated pin rests at the level its termination gives it
	localparam cops_pin_type PIN_RUN    = '{true_drive: 1'b1, true_level: 1'b0, true_strong: 1'b0,
		comp_drive: 1'b1, comp_level: 1'b1};
	localparam cops_pin_type PIN_FLOAT  = '{true_drive: 1'b0, true_level: 1'b0, true_strong: 1'b0,
		comp_drive: 1'b0, comp_level: 1'b0};
	localparam cops_pin_type PIN_HIGH   = '{true_drive: 1'b1, true_level: 1'b1, true_strong: 1'b0,
		comp_drive: 1'b0, comp_level: 1'b0};
	localparam cops_pin_type PIN_STRONG = '{true_drive: 1'b1, true_level: 1'b1, true_strong: 1'b1,
		comp_drive: 1'b0, comp_level: 1'b0};

	function automatic cops_pin_type pair_state(
		input logic en, input logic pd, input logic pd_s,
		input logic hlt, input logic hlt_s, input logic rel_drv, input logic pd_wake);
		cops_pin_type p;
		p = PIN_RUN;
		if (!en) begin
			p = PIN_FLOAT;
		end else if (pd && !(pd_s && pd_wake)) begin
			if (!pd_s)
				p = PIN_HIGH;
			else
				p = PIN_FLOAT;
		end else if (pd) begin
			p = PIN_HIGH;
		end else if (hlt && !(hlt_s && rel_drv)) begin
			if (!hlt_s)
				p = PIN_STRONG;
			else
				p = PIN_FLOAT;
		end else if (hlt) begin
			p = PIN_HIGH;
		end
		pair_state = p;
	endfunction : pair_state

	cops_pin_type     pin_nxt [n_out];
	wire logic [n_out-1:0] run_nxt;

	// ----------------------------------------------------------------
	// per-pair output registers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < n_out; g++) begin : g_pair
			assign pin_nxt[g] = pair_state(enable_r[g], parked_pd, pd_sel,
				halted_r[g], halt_sel, halt_rel_drive, pd_waking);
			assign run_nxt[g] = enable_r[g] && !parked_pd && !halted_r[g] && locked;
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					clock_out_true_oe[g]     <= 1'b0;
					clock_out_true_level[g]  <= 1'b0;
					clock_out_true_strong[g] <= 1'b0;
					clock_out_comp_oe[g]     <= 1'b0;
					clock_out_comp_level[g]  <= 1'b0;
					clock_run[g]             <= 1'b0;
				end else begin
					clock_out_true_oe[g]     <= pin_nxt[g].true_drive;
					clock_out_true_level[g]  <= pin_nxt[g].true_level;
					clock_out_true_strong[g] <= pin_nxt[g].true_strong;
					clock_out_comp_oe[g]     <= pin_nxt[g].comp_drive;
					clock_out_comp_level[g]  <= pin_nxt[g].comp_level;
					clock_run[g]             <= run_nxt[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata           <= 8'h00;
			readback_count_bits <= COPS_RST_READBACK_CNT;
			pll_enable          <= 1'b0;
			pll_locked          <= 1'b0;
		end else begin
			reg_rdata           <= rdata_mux;
			readback_count_bits <= readback_cnt_r;
			pll_enable          <= pll_on;
			pll_locked          <= locked;
		end
	end

endmodule : cops_ctrl
`default_nettype wire

//--- cops_ctrl_bench.sv
// cops_ctrl_bench: self-checking bench for cops_ctrl beside the power-management model
// assumes: package, design, checker and model compiled first
`timescale 1ns/1ns
`default_nettype none
module cops_ctrl_bench
	import cops_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       reg_wr = 1'b0;
	logic       pd_req = 1'b1;
	logic       halt_req = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       pd_n, halt_n, cer, cef, pll_en, locked;
	logic [7:0] rdata, rbc, run, t_oe, t_lv, t_st, c_oe, c_lv, d, s, e;
	int         miscompares = 0;
	int         checks_done = 0;
	int         cycles = 0;
	always #25 clk = ~clk;
	// short lock and wake counts keep the run brief
	cops_ctrl #(.n_out(8), .lock_cycles(20), .pd_drive_cyc(5)) uut (.clk(clk), .rst_n(rst_n),
		.power_down_n(pd_n), .output_halt_n(halt_n), .comp_edge_rise(cer), .comp_edge_fall(cef),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.readback_count_bits(rbc), .pll_enable(pll_en), .pll_locked(locked), .clock_run(run),
		.clock_out_true_oe(t_oe), .clock_out_true_level(t_lv), .clock_out_true_strong(t_st),
		.clock_out_comp_oe(c_oe), .clock_out_comp_level(c_lv));
	cops_pm_model u_pm (.clk(clk), .rst_n(rst_n), .pll_enable(pll_en), .pd_req(pd_req),
		.halt_req(halt_req), .power_down_n(pd_n), .output_halt_n(halt_n), .comp_edge_rise(cer),
		.comp_edge_fall(cef));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] parked(input logic sel, input logic [7:0] m);
		return sel ? 8'h00 : m;
	endfunction : parked
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		checks_done++;
		if (g !== x) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		@(negedge clk);
		chk(rdata, x);
	endtask : rd
	task automatic wait_pll(input logic v, input int n);
		for (int i = 0; i < n && {pll_en, locked} !== {v, v}; i++) @(negedge clk);
		chk({6'h00, pll_en, locked}, {6'h00, v, v});
	endtask : wait_pll
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(18437));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(COPS_OFS_REV_VENDOR, {COPS_REVISION_CODE, COPS_MAKER_CODE});
		rd(COPS_OFS_PART_IDENT, COPS_RST_PART_IDENT);
		rd(COPS_OFS_READBACK_CNT, 8'h07);
		rd(COPS_OFS_STOPPABLE, 8'h00);
		chk(rbc, 8'h07);
		wr(COPS_OFS_REV_VENDOR, 8'hc3);
		rd(COPS_OFS_REV_VENDOR, {COPS_REVISION_CODE, COPS_MAKER_CODE});
		rd(8'h03, 8'h00);
		$display("test reset_values done");
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'hff : 8'($urandom);
			wr(COPS_OFS_READBACK_CNT, d);
			rd(COPS_OFS_READBACK_CNT, d);
			chk(rbc, d);
			wr(COPS_OFS_PART_IDENT, ~d);
			rd(COPS_OFS_PART_IDENT, ~d);
		end
		$display("test registers done");
		for (int m = 0; m < 2; m++) begin
			wr(COPS_OFS_DRIVE_MODE, {m[0], 7'h07});
			@(posedge clk) pd_req <= 1'b0;
			wait_pll(1'b0, 100);
			chk(t_oe, parked(m[0], 8'hff));
			chk(c_oe, 8'h00);
			chk(t_lv, parked(m[0], 8'hff));
			chk(c_lv, 8'h00);
			@(posedge clk) pd_req <= 1'b1;
			wait_pll(1'b1, 60);
			chk(run, 8'hff);
		end
		$display("test power_down done");
		e = ~(8'h01 << ($urandom % 8));
		for (int m = 0; m < 2; m++) begin
			s = 8'($urandom) | 8'h01;
			wr(COPS_OFS_DRIVE_MODE, {1'b0, m[0], 6'h07});
			wr(COPS_OFS_STOPPABLE, s);
			wr(COPS_OFS_ENABLE, e);
			@(posedge clk) halt_req <= 1'b0;
			repeat (3) @(posedge clk);
			halt_req <= 1'b1;
			repeat (24) @(negedge clk);
			chk(run & e, e);
			@(posedge clk) halt_req <= 1'b0;
			repeat (40) @(negedge clk);
			chk(run & e, e & ~s);
			chk(t_oe & e & s, parked(m[0], e & s));
			chk(c_oe & e & s, 8'h00);
			chk(t_st & e & s, parked(m[0], e & s));
			chk(c_lv & e & s, 8'h00);
			@(posedge clk) halt_req <= 1'b1;
			repeat (48) @(negedge clk);
			chk(run & e, e);
		end
		$display("test output_halt done");
		tally_and_finish();
	end
endmodule : cops_ctrl_bench
`default_nettype wire

//--- cops_ctrl_checker.sv
// cops_ctrl_checker: port-level checks of cops_ctrl
// assumes: bound into cops_ctrl, single clock, sync active-low reset
`timescale 1ns/1ns
`default_nettype none
module cops_ctrl_checker
	import cops_pkg::*;
#(
	parameter int n_out        = 8,
	parameter int lock_cycles  = COPS_LOCK_CYCLES,
	parameter int pd_drive_cyc = COPS_PD_DRIVE_CYCLES
) (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic             power_down_n,
	input wire logic             output_halt_n,
	input wire logic             comp_edge_fall,
	input wire logic             reg_wr,
	input wire logic [7:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic [7:0]       readback_count_bits,
	input wire logic             pll_enable,
	input wire logic             pll_locked,
	input wire logic [n_out-1:0] clock_run,
	input wire logic [n_out-1:0] clock_out_true_oe,
	input wire logic [n_out-1:0] clock_out_comp_oe
);
	// ----------------------------------------------------------------
	// mirror of the config registers
	// ----------------------------------------------------------------
	logic [7:0]       mode_r;
	logic [n_out-1:0] en_r;
	logic [n_out-1:0] stp_r;
	logic [n_out-1:0] run_r;
	logic [15:0]      wake_r;
	wire  logic [n_out-1:0] fell_m = run_r & ~clock_run & en_r;
	wire  logic [n_out-1:0] rose_m = clock_run & ~run_r & en_r;
	wire  logic [n_out-1:0] hlt_m  = en_r & ~clock_run;
	always_ff @(posedge clk) begin
		run_r <= clock_run;
		wake_r <= (!rst_n || pll_locked || !power_down_n) ? 16'h0000 : wake_r + 16'h0001;
		if (!rst_n) begin
			mode_r <= COPS_RST_DRIVE_MODE;
			en_r <= COPS_RST_ENABLE[n_out-1:0];
			stp_r <= COPS_RST_STOPPABLE[n_out-1:0];
		end else if (reg_wr) begin
			if (reg_addr == COPS_OFS_DRIVE_MODE) mode_r <= reg_wdata;
			if (reg_addr == COPS_OFS_ENABLE) en_r <= reg_wdata[n_out-1:0];
			if (reg_addr == COPS_OFS_STOPPABLE) stp_r <= reg_wdata[n_out-1:0];
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_parked;
		!pll_enable && !power_down_n && $past(!pll_enable);
	endsequence
	sequence s_release;
		$rose(output_halt_n) && mode_r[COPS_BIT_HALT_DRIVE_SELECT] && pll_locked;
	endsequence
	a_count_write_lands: assert property (reg_wr && reg_addr == COPS_OFS_READBACK_CNT
		|-> ##2 readback_count_bits == $past(reg_wdata, 2)) else $error("count write lost");
	a_park_then_pll: assert property ($fell(pll_enable)
		|-> clock_run == '0 && ($past(comp_edge_fall) || $past(comp_edge_fall, 2))) else $error("bad pd entry");
	a_pd_park_state: assert property (s_parked |-> (clock_out_comp_oe & en_r) == '0 &&
		(clock_out_true_oe & en_r) == (mode_r[COPS_BIT_PD_DRIVE_SELECT] ? '0 : en_r)) else $error("bad park");
	a_wake_drive_up: assert property ($rose(power_down_n) && !pll_enable && mode_r[COPS_BIT_PD_DRIVE_SELECT]
		|-> ##[1:3] (clock_out_true_oe & en_r) == en_r) else $error("wake not driven");
	a_lock_in_time: assert property (wake_r < lock_cycles + 4) else $error("lock too late");
	a_halt_at_fall: assert property (pll_locked && $past(pll_locked) && fell_m != '0
		|-> ($past(comp_edge_fall) || $past(comp_edge_fall, 2)) && (fell_m & ~stp_r) == '0) else $error("bad halt");
	a_restart_together: assert property (pll_locked && $past(pll_locked) && rose_m != '0
		|-> (clock_run & en_r) == en_r && ($past(comp_edge_fall) || $past(comp_edge_fall, 2))) else $error("bad restart");
	a_halt_comp_float: assert property (pll_locked |-> (clock_out_comp_oe & hlt_m) == '0)
		else $error("comp driven while halted");
	a_release_drive_up: assert property (s_release
		|-> ##[1:24] (clock_out_true_oe & en_r) == en_r) else $error("release not driven");
endmodule : cops_ctrl_checker
bind cops_ctrl cops_ctrl_checker #(.n_out(n_out), .lock_cycles(lock_cycles), .pd_drive_cyc(pd_drive_cyc)) u_chk (
	.clk(clk), .rst_n(rst_n), .power_down_n(power_down_n), .output_halt_n(output_halt_n),
	.comp_edge_fall(comp_edge_fall), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.readback_count_bits(readback_count_bits), .pll_enable(pll_enable), .pll_locked(pll_locked),
	.clock_run(clock_run), .clock_out_true_oe(clock_out_true_oe), .clock_out_comp_oe(clock_out_comp_oe));
`default_nettype wire

//--- cops_debounce.sv
// cops_debounce: accepts a new level after it holds on a set number of sampling edges
// assumes: sample_en marks one rising edge of the complementary output clock
`timescale 1ns/1ns
`default_nettype none
module cops_debounce
	import cops_pkg::*;
#(
	parameter logic level_rst = 1'b1,
	parameter int   edges     = COPS_DEBOUNCE_EDGES
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic sample_en,
	input  wire logic level_in,
	output var  logic level_out
);

	// ----------------------------------------------------------------
	// hold counter
	// ----------------------------------------------------------------
	logic [3:0] hold_r;
	logic       level_r;
	wire  logic differs = (level_in != level_r);
	wire  logic accept  = sample_en && differs && (hold_r == 4'(edges - 1));

	if (edges < 1 || edges > 15) begin : g_bad_edges
		$error("cops_debounce: edges out of range");
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_r  <= 4'h0;
			level_r <= level_rst;
		end else if (sample_en) begin
			hold_r  <= (differs && !accept) ? hold_r + 4'h1 : 4'h0;
			level_r <= accept ? level_in : level_r;
		end
	end

	assign level_out = level_r;

endmodule : cops_debounce
`default_nettype wire

//--- cops_pkg.sv
// cops_pkg: constants and carrier types for the clock output power/stop control block
// assumes: a single 20 MHz clock domain with synchronous active-low reset
package cops_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] COPS_OFS_DRIVE_MODE   = 8'h00;
	localparam logic [7:0] COPS_OFS_ENABLE       = 8'h01;
	localparam logic [7:0] COPS_OFS_STOPPABLE    = 8'h02;
	localparam logic [7:0] COPS_OFS_REV_VENDOR   = 8'h04;
	localparam logic [7:0] COPS_OFS_PART_IDENT   = 8'h05;
	localparam logic [7:0] COPS_OFS_READBACK_CNT = 8'h06;

	// field positions in the drive-mode register
	localparam int COPS_BIT_PD_DRIVE_SELECT   = 7;
	localparam int COPS_BIT_HALT_DRIVE_SELECT = 6;

	// reset values
	localparam logic [7:0] COPS_RST_DRIVE_MODE   = 8'h07;
	localparam logic [7:0] COPS_RST_ENABLE       = 8'hff;
	localparam logic [7:0] COPS_RST_STOPPABLE    = 8'h00;
	localparam logic [7:0] COPS_RST_READBACK_CNT = 8'h07;
	localparam logic [7:0] COPS_RST_PART_IDENT   = 8'h5a; // arbitrary value
	localparam logic [3:0] COPS_REVISION_CODE    = 4'h1;  // arbitrary value
	localparam logic [3:0] COPS_MAKER_CODE       = 4'h6;  // arbitrary value

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int COPS_CLK_PERIOD_NS   = 50;
	localparam int COPS_LOCK_TIME_US    = 1000;
	localparam int COPS_LOCK_CYCLES     = (COPS_LOCK_TIME_US * 1000) / COPS_CLK_PERIOD_NS;
	localparam int COPS_PD_DRIVE_US     = 300;
	localparam int COPS_PD_DRIVE_CYCLES = (COPS_PD_DRIVE_US * 1000) / COPS_CLK_PERIOD_NS;
	localparam int COPS_HALT_DRIVE_NS   = 10;
	localparam int COPS_HALT_DRIVE_CYC  = (COPS_HALT_DRIVE_NS >= COPS_CLK_PERIOD_NS) ?
		COPS_HALT_DRIVE_NS / COPS_CLK_PERIOD_NS : 1;
	localparam int COPS_DEBOUNCE_EDGES  = 2;
	localparam int COPS_RESTART_MIN     = 2;
	localparam int COPS_RESTART_MAX     = 6;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		COPS_ST_RUN      = 3'b000,
		COPS_ST_PD_PARK  = 3'b001,
		COPS_ST_PD_OFF   = 3'b010,
		COPS_ST_PD_WAKE  = 3'b011,
		COPS_ST_LOCKWAIT = 3'b100
	} cops_state_type;

	typedef struct packed {
		logic [7:0] wdata;
		logic [7:0] addr;
		logic       wr;
	} cops_regreq_type;

	typedef struct packed {
		logic true_drive;
		logic true_level;
		logic true_strong;
		logic comp_drive;
		logic comp_level;
	} cops_pin_type;

endpackage : cops_pkg

//--- cops_pm_model.sv
// cops_pm_model: power-management side driving the control pins and the output clock edge marks
// assumes: bench asks for pin levels on pd_req and halt_req, one clk domain
`timescale 1ns/1ns
`default_nettype none
module cops_pm_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pll_enable,
	input  wire logic pd_req,
	input  wire logic halt_req,
	output var  logic power_down_n,
	output var  logic output_halt_n,
	output var  logic comp_edge_rise,
	output var  logic comp_edge_fall
);
	logic [2:0] ph_r = 3'h0;
	initial begin
		power_down_n = 1'b1;
		output_halt_n = 1'b1;
		comp_edge_rise = 1'b0;
		comp_edge_fall = 1'b0;
	end
	// output clock stands still once the pll is off; the control pins follow the requests whether or not it runs
	always @(posedge clk) begin
		ph_r <= (!rst_n || !pll_enable) ? 3'h0 : ph_r + 3'h1;
		comp_edge_rise <= pll_enable && ph_r == 3'h0;
		comp_edge_fall <= pll_enable && ph_r == 3'h4;
		power_down_n <= !rst_n || pd_req;
		output_halt_n <= !rst_n || halt_req;
	end
endmodule : cops_pm_model
`default_nettype wire
